// file: verilog/rail_cfg_pkg.sv
// Register map, field layout and reset values of the rail enable block
package rail_cfg_pkg;

    localparam logic [7:0] ADDR_RAIL = 8'h16;
    localparam logic [7:0] ADDR_LOCKOUT = 8'h18;
    localparam logic [7:0] ADDR_SLOTS = 8'h19;

    localparam logic [7:0] RAIL_RESET = 8'h00;
    localparam logic [7:0] LOCKOUT_RESET = 8'h03;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // Writable bits; the rest read as zero
    localparam logic [7:0] RAIL_WMASK = 8'h7f;
    localparam logic [7:0] LOCKOUT_WMASK = 8'h07;
    localparam logic [7:0] SLOTS_WMASK = 8'h77;

    localparam int BIT_SWITCH_ONE = 6;
    localparam int BIT_SWITCH_TWO = 5;
    localparam int BIT_BUCK_ONE = 4;
    localparam int BIT_BUCK_TWO = 3;
    localparam int BIT_BUCK_THREE = 2;
    localparam int BIT_LINREG_ONE = 1;
    localparam int BIT_LINREG_TWO = 0;

    localparam int LOCKOUT_FIELD_LSB = 0;
    localparam int LOCKOUT_SPARE_BIT = 2;

    localparam int SLOT_ONE_LSB = 4;
    localparam int SLOT_TWO_LSB = 0;
    localparam logic [2:0] SLOT_OFF = 3'h0;
    localparam logic [2:0] SLOT_ONE_RESET = 3'h1;
    localparam logic [2:0] SLOT_TWO_RESET_FIRST = 3'h2;
    localparam logic [2:0] SLOT_TWO_RESET_OTHER = 3'h5;

    typedef enum logic [1:0] {
        LOCKOUT_2V73 = 2'b00,
        LOCKOUT_2V89 = 2'b01,
        LOCKOUT_3V18 = 2'b10,
        LOCKOUT_3V30 = 2'b11
    } lockout_code_e;

    // True when a strobe event reaches a rail whose slot is under sequencer control
    function automatic logic slot_hit(input logic [2:0] slot, input logic [2:0] strobe_num);
        slot_hit = (slot != SLOT_OFF) && (slot == strobe_num);
    endfunction

endpackage

// file: verilog/pin_sync.sv
// Two-flop synchroniser for an asynchronous pin
`timescale 1ns/1ps
module pin_sync (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic pin_in,
    output logic pin_sync_r
);
    logic meta_r;
    logic meta_nxt;
    logic sync_nxt;

    always_comb begin
        meta_nxt = pin_in;
        sync_nxt = meta_r;
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            meta_r <= 1'b0;
            pin_sync_r <= 1'b0;
        end else begin
            meta_r <= meta_nxt;
            pin_sync_r <= sync_nxt;
        end
    end
endmodule

// file: verilog/slot_latch.sv
// Remembers that a rail's sequencer strobe slot has been reached
`timescale 1ns/1ps
module slot_latch (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [2:0] slot,
    input wire logic strobe_pulse,
    input wire logic [2:0] strobe_num,
    input wire logic seq_restart,
    output logic reached_r
);
    logic reached_nxt;

    always_comb begin
        reached_nxt = reached_r;
        if (seq_restart) begin
            reached_nxt = 1'b0;
        end
        // A strobe in the restart cycle still counts
        if (strobe_pulse && rail_cfg_pkg::slot_hit(slot, strobe_num)) begin
            reached_nxt = 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            reached_r <= 1'b0;
        end else begin
            reached_r <= reached_nxt;
        end
    end
endmodule

// file: verilog/rail_enable_and_strobe_config.sv
// Rail enable, lockout threshold and strobe slot registers with rail gating
// Functional notes
// [R1] Rail enable register at 0x16, resets zero
// [R2] Bit 6 switch one, needs power pin high
// [R3] Bit 5 switch two, needs power pin high
// [R4] Bits 4..2 bucks one..three, need pin
// [R5] Bits 1,0 linear regulators, no pin condition
// [R6] All three registers are write protected
// [R7] Lockout register 0x18, reset 0x03, top zero
// [R8] Lockout threshold field bits 1:0, reset 11
// [R9] Bit 2 spare read/write, resets zero
// [R10] Slot register 0x19, fields 6-4, 2-0
// [R11] Slot zero: no sequencing; n: strobe n
// [R12] Buck two slot reset depends on variant
// [R13] Pin-gated rails: enable bit AND pin
// [R14] Protected writes need a preceding unlock
`timescale 1ns/1ps
module rail_enable_and_strobe_config #(
    parameter bit FIRST_VARIANT = 1'b0
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic unlock_pulse,
    input wire logic power_enable_pin,
    input wire logic strobe_pulse,
    input wire logic [2:0] strobe_num,
    input wire logic seq_restart,
    output logic [7:0] reg_rdata_r,
    output logic wr_refused_r,
    output logic switch_one_on_r,
    output logic switch_two_on_r,
    output logic buck_one_on_r,
    output logic buck_two_on_r,
    output logic buck_three_on_r,
    output logic linreg_one_on_r,
    output logic linreg_two_on_r,
    output logic [1:0] lockout_threshold_field_r
);
    localparam logic [2:0] SLOT_TWO_RESET = FIRST_VARIANT ?
        rail_cfg_pkg::SLOT_TWO_RESET_FIRST : rail_cfg_pkg::SLOT_TWO_RESET_OTHER;
    localparam logic [7:0] SLOTS_RESET = {1'b0, rail_cfg_pkg::SLOT_ONE_RESET,
        1'b0, SLOT_TWO_RESET};

    logic pwr_sync;
    logic reached_one;
    logic reached_two;

    logic [7:0] rail_enable_bits_r;
    logic [7:0] rail_enable_bits_nxt;
    logic [7:0] lockout_threshold_r;
    logic [7:0] lockout_threshold_nxt;
    logic [7:0] sequencer_slots_one_r;
    logic [7:0] sequencer_slots_one_nxt;
    logic unlock_armed_r;
    logic unlock_armed_nxt;
    logic [7:0] reg_rdata_nxt;
    logic wr_refused_nxt;
    logic write_ok;
    logic hit_mapped;

    logic switch_one_on_nxt;
    logic switch_two_on_nxt;
    logic buck_one_on_nxt;
    logic buck_two_on_nxt;
    logic buck_three_on_nxt;
    logic linreg_one_on_nxt;
    logic linreg_two_on_nxt;
    logic [1:0] lockout_threshold_field_nxt;

    logic [2:0] buck_one_slot;
    logic [2:0] buck_two_slot;

    pin_sync u_pwr_sync (
        .mclk(mclk),
        .rst_b(rst_b),
        .pin_in(power_enable_pin),
        .pin_sync_r(pwr_sync)
    );

    assign buck_one_slot = sequencer_slots_one_r[rail_cfg_pkg::SLOT_ONE_LSB +: 3]; // [R10]
    assign buck_two_slot = sequencer_slots_one_r[rail_cfg_pkg::SLOT_TWO_LSB +: 3]; // [R10]

    slot_latch u_slot_one (
        .mclk(mclk),
        .rst_b(rst_b),
        .slot(buck_one_slot),
        .strobe_pulse(strobe_pulse),
        .strobe_num(strobe_num),
        .seq_restart(seq_restart),
        .reached_r(reached_one)
    );

    slot_latch u_slot_two (
        .mclk(mclk),
        .rst_b(rst_b),
        .slot(buck_two_slot),
        .strobe_pulse(strobe_pulse),
        .strobe_num(strobe_num),
        .seq_restart(seq_restart),
        .reached_r(reached_two)
    );

    // Register access and the one-shot unlock
    always_comb begin
        hit_mapped = (reg_addr == rail_cfg_pkg::ADDR_RAIL) ||
            (reg_addr == rail_cfg_pkg::ADDR_LOCKOUT) ||
            (reg_addr == rail_cfg_pkg::ADDR_SLOTS);
        write_ok = reg_wr && unlock_armed_r && hit_mapped; // [R6] [R14]
        rail_enable_bits_nxt = rail_enable_bits_r;
        lockout_threshold_nxt = lockout_threshold_r;
        sequencer_slots_one_nxt = sequencer_slots_one_r;
        if (write_ok) begin
            unique case (reg_addr)
                rail_cfg_pkg::ADDR_RAIL: begin
                    rail_enable_bits_nxt = reg_wdata & rail_cfg_pkg::RAIL_WMASK; // [R1]
                end
                rail_cfg_pkg::ADDR_LOCKOUT: begin
                    lockout_threshold_nxt = reg_wdata & rail_cfg_pkg::LOCKOUT_WMASK; // [R7] [R9]
                end
                rail_cfg_pkg::ADDR_SLOTS: begin
                    sequencer_slots_one_nxt = reg_wdata & rail_cfg_pkg::SLOTS_WMASK; // [R10]
                end
                default: begin
                    rail_enable_bits_nxt = rail_enable_bits_r;
                end
            endcase
        end
        // Any write uses up the unlock; a fresh unlock in the same cycle wins
        unlock_armed_nxt = unlock_armed_r;
        if (reg_wr) begin
            unlock_armed_nxt = 1'b0; // [R14]
        end
        if (unlock_pulse) begin
            unlock_armed_nxt = 1'b1;
        end
        wr_refused_nxt = reg_wr && hit_mapped && !unlock_armed_r; // [R14]
        reg_rdata_nxt = reg_rdata_r;
        if (reg_rd) begin
            if (reg_addr == rail_cfg_pkg::ADDR_RAIL) begin
                reg_rdata_nxt = rail_enable_bits_r;
            end else if (reg_addr == rail_cfg_pkg::ADDR_LOCKOUT) begin
                reg_rdata_nxt = lockout_threshold_r;
            end else if (reg_addr == rail_cfg_pkg::ADDR_SLOTS) begin
                reg_rdata_nxt = sequencer_slots_one_r;
            end else begin
                reg_rdata_nxt = rail_cfg_pkg::READ_UNMAPPED;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rail_enable_bits_r <= rail_cfg_pkg::RAIL_RESET; // [R1]
            lockout_threshold_r <= rail_cfg_pkg::LOCKOUT_RESET; // [R7] [R8] [R9]
            sequencer_slots_one_r <= SLOTS_RESET; // [R12]
            unlock_armed_r <= 1'b0;
            wr_refused_r <= 1'b0;
            reg_rdata_r <= 8'h00;
        end else begin
            rail_enable_bits_r <= rail_enable_bits_nxt;
            lockout_threshold_r <= lockout_threshold_nxt;
            sequencer_slots_one_r <= sequencer_slots_one_nxt;
            unlock_armed_r <= unlock_armed_nxt;
            wr_refused_r <= wr_refused_nxt;
            reg_rdata_r <= reg_rdata_nxt;
        end
    end

    // Rail requests; the pin is sampled synchronised, so outputs lag it by three edges
    always_comb begin
        switch_one_on_nxt = rail_enable_bits_r[rail_cfg_pkg::BIT_SWITCH_ONE] && pwr_sync; // [R2] [R13]
        switch_two_on_nxt = rail_enable_bits_r[rail_cfg_pkg::BIT_SWITCH_TWO] && pwr_sync; // [R3] [R13]
        // Sequencer slots also turn bucks one and two on, but never without the pin
        buck_one_on_nxt = (rail_enable_bits_r[rail_cfg_pkg::BIT_BUCK_ONE] || reached_one) &&
            pwr_sync; // [R4] [R11] [R13]
        buck_two_on_nxt = (rail_enable_bits_r[rail_cfg_pkg::BIT_BUCK_TWO] || reached_two) &&
            pwr_sync; // [R4] [R11] [R13]
        buck_three_on_nxt = rail_enable_bits_r[rail_cfg_pkg::BIT_BUCK_THREE] && pwr_sync; // [R4]
        linreg_one_on_nxt = rail_enable_bits_r[rail_cfg_pkg::BIT_LINREG_ONE]; // [R5]
        linreg_two_on_nxt = rail_enable_bits_r[rail_cfg_pkg::BIT_LINREG_TWO]; // [R5]
        lockout_threshold_field_nxt =
            lockout_threshold_r[rail_cfg_pkg::LOCKOUT_FIELD_LSB +: 2]; // [R8]
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            switch_one_on_r <= 1'b0;
            switch_two_on_r <= 1'b0;
            buck_one_on_r <= 1'b0;
            buck_two_on_r <= 1'b0;
            buck_three_on_r <= 1'b0;
            linreg_one_on_r <= 1'b0;
            linreg_two_on_r <= 1'b0;
            lockout_threshold_field_r <= rail_cfg_pkg::LOCKOUT_RESET[1:0];
        end else begin
            switch_one_on_r <= switch_one_on_nxt;
            switch_two_on_r <= switch_two_on_nxt;
            buck_one_on_r <= buck_one_on_nxt;
            buck_two_on_r <= buck_two_on_nxt;
            buck_three_on_r <= buck_three_on_nxt;
            linreg_one_on_r <= linreg_one_on_nxt;
            linreg_two_on_r <= linreg_two_on_nxt;
            lockout_threshold_field_r <= lockout_threshold_field_nxt;
        end
    end

    AST_RAIL_READBACK: assert property (@(posedge mclk) disable iff (!rst_b) // [R1]
        reg_rd && reg_addr == 8'h16 |=> reg_rdata_r == $past(rail_enable_bits_r) &&
        reg_rdata_r[7] == 1'b0)
        else $error("rail enable readback wrong");

    AST_SWITCH_ONE_GATED: assert property (@(posedge mclk) disable iff (!rst_b) // [R2]
        switch_one_on_r |-> $past(rail_enable_bits_r[6]) && $past(pwr_sync))
        else $error("switch one on without bit and pin");

    AST_SWITCH_TWO_GATED: assert property (@(posedge mclk) disable iff (!rst_b) // [R3]
        switch_two_on_r |-> $past(rail_enable_bits_r[5]) && $past(pwr_sync))
        else $error("switch two turned on without bit and pin");

    AST_BUCKS_NEED_PIN: assert property (@(posedge mclk) disable iff (!rst_b) // [R4]
        !pwr_sync |=> !buck_one_on_r && !buck_two_on_r && !buck_three_on_r)
        else $error("buck on while power pin low");

    AST_LINREGS_FOLLOW_BITS: assert property (@(posedge mclk) disable iff (!rst_b) // [R5]
        ##1 {linreg_one_on_r, linreg_two_on_r} == $past(rail_enable_bits_r[1:0]))
        else $error("linear regulator enables do not follow bits");

    AST_LOCKED_WRITE_IGNORED: assert property (@(posedge mclk) disable iff (!rst_b) // [R6]
        reg_wr && !unlock_armed_r |=> $stable(rail_enable_bits_r) &&
        $stable(lockout_threshold_r) && $stable(sequencer_slots_one_r))
        else $error("protected register changed without unlock");

    AST_LOCKOUT_TOP_ZERO: assert property (@(posedge mclk) disable iff (!rst_b) // [R7]
        lockout_threshold_r[7:3] == 5'h00 && sequencer_slots_one_r[7] == 1'b0 &&
        sequencer_slots_one_r[3] == 1'b0)
        else $error("reserved bits not zero");

    AST_THRESHOLD_OUT: assert property (@(posedge mclk) disable iff (!rst_b) // [R8]
        write_ok && reg_addr == 8'h18 |=> ##1 lockout_threshold_field_r == $past(reg_wdata[1:0], 2))
        else $error("threshold field not driven from write");

    AST_SPARE_BIT_RW: assert property (@(posedge mclk) disable iff (!rst_b) // [R9]
        write_ok && reg_addr == 8'h18 |=> lockout_threshold_r[2] == $past(reg_wdata[2]))
        else $error("spare lockout bit not stored");

    AST_SLOT_WRITE: assert property (@(posedge mclk) disable iff (!rst_b) // [R10]
        write_ok && reg_addr == 8'h19 |=> buck_one_slot == $past(reg_wdata[6:4]) &&
        buck_two_slot == $past(reg_wdata[2:0]))
        else $error("slot fields not stored");

    AST_SLOT_ZERO_NO_SEQ: assert property (@(posedge mclk) disable iff (!rst_b) // [R11]
        $rose(reached_one) |-> $past(strobe_pulse) && $past(buck_one_slot) != 3'h0 &&
        $past(strobe_num) == $past(buck_one_slot))
        else $error("buck one sequenced at wrong strobe");

    AST_SLOT_REACH: assert property (@(posedge mclk) disable iff (!rst_b) // [R11]
        strobe_pulse && buck_two_slot != 3'h0 && strobe_num == buck_two_slot |=> reached_two)
        else $error("buck two slot not reached");

    AST_PIN_AND: assert property (@(posedge mclk) disable iff (!rst_b) // [R13]
        pwr_sync && rail_enable_bits_r[2] ##1 pwr_sync && rail_enable_bits_r[2]
        |-> ##1 buck_three_on_r)
        else $error("buck three off while bit and pin high");

    AST_UNLOCK_ONE_SHOT: assert property (@(posedge mclk) disable iff (!rst_b) // [R14]
        reg_wr && !unlock_pulse ##1 reg_wr && reg_addr == 8'h16 && !unlock_pulse
        |=> $stable(rail_enable_bits_r) && wr_refused_r)
        else $error("second write after one unlock accepted");

    AST_REFUSED_PULSE: assert property (@(posedge mclk) disable iff (!rst_b) // [R14]
        wr_refused_r == ($past(reg_wr) && $past(hit_mapped) && !$past(unlock_armed_r)))
        else $error("write refusal flag wrong");

    AST_BUCK_TWO_SOURCES: assert property (@(posedge mclk) disable iff (!rst_b) // [R11]
        buck_two_on_r |-> $past(pwr_sync) &&
        ($past(rail_enable_bits_r[3]) || $past(reached_two)))
        else $error("buck two on without enable, slot or pin");

    AST_RAIL_TOP_ZERO: assert property (@(posedge mclk) disable iff (!rst_b) // [R1]
        rail_enable_bits_r[7] == 1'b0)
        else $error("rail enable bit 7 not zero");

    // Reset values checked at the first sampled edge after release
    logic first_cycle_r;
    logic first_cycle_nxt;

    always_comb begin
        first_cycle_nxt = 1'b0;
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            first_cycle_r <= 1'b1;
        end else begin
            first_cycle_r <= first_cycle_nxt;
        end
    end

    AST_RESET_VALUES: assert property (@(posedge mclk) disable iff (!rst_b) // [R12]
        first_cycle_r |-> buck_one_slot == 3'h1 &&
        buck_two_slot == (FIRST_VARIANT ? 3'h2 : 3'h5) && lockout_threshold_r == 8'h03 &&
        rail_enable_bits_r == 8'h00)
        else $error("register reset values wrong");
endmodule

// file: tb/rail_enable_and_strobe_config_tb_top.sv
// Self-checking bench for the rail enable, lockout and strobe slot registers
`timescale 1ns/1ps
module rail_enable_and_strobe_config_tb_top;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic unlock_pulse = 1'b0;
    logic power_enable_pin = 1'b0;
    logic strobe_pulse = 1'b0;
    logic [2:0] strobe_num = 3'h0;
    logic seq_restart = 1'b0;
    logic [7:0] reg_rdata_r;
    logic wr_refused_r;
    logic switch_one_on_r, switch_two_on_r, buck_one_on_r, buck_two_on_r;
    logic buck_three_on_r, linreg_one_on_r, linreg_two_on_r;
    logic [1:0] lockout_threshold_field_r;
    logic [6:0] rails;
    int mismatches = 0;
    int tests_run = 0;

    assign rails = {switch_one_on_r, switch_two_on_r, buck_one_on_r, buck_two_on_r,
                    buck_three_on_r, linreg_one_on_r, linreg_two_on_r};

    always #5 mclk = ~mclk;

    rail_enable_and_strobe_config #(.FIRST_VARIANT(1'b0)) i_rail_enable_and_strobe_config (
        .mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .unlock_pulse(unlock_pulse),
        .power_enable_pin(power_enable_pin), .strobe_pulse(strobe_pulse),
        .strobe_num(strobe_num), .seq_restart(seq_restart), .reg_rdata_r(reg_rdata_r),
        .wr_refused_r(wr_refused_r), .switch_one_on_r(switch_one_on_r),
        .switch_two_on_r(switch_two_on_r), .buck_one_on_r(buck_one_on_r),
        .buck_two_on_r(buck_two_on_r), .buck_three_on_r(buck_three_on_r),
        .linreg_one_on_r(linreg_one_on_r), .linreg_two_on_r(linreg_two_on_r),
        .lockout_threshold_field_r(lockout_threshold_field_r)
    );

    task automatic results;
        if (mismatches == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Inputs always move 1 ns after the rising edge, clear of the sampling point
    task automatic tick(input int n = 1);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic unl,
                      output logic rf);
        if (unl) begin
            unlock_pulse = 1'b1;
            tick();
            unlock_pulse = 1'b0;
        end
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        tick();
        rf = wr_refused_r;
        reg_wr = 1'b0;
        // An idle edge so the next call never lowers and raises the strobe in one step
        tick();
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        reg_addr = a;
        reg_rd = 1'b1;
        tick();
        q = reg_rdata_r;
        reg_rd = 1'b0;
        tick();
    endtask

    task automatic pin(input logic v);
        power_enable_pin = v;
        // Two synchroniser flops plus the output register
        tick(4);
    endtask

    task automatic strobe(input logic [2:0] n);
        strobe_num = n;
        strobe_pulse = 1'b1;
        tick();
        strobe_pulse = 1'b0;
        tick(2);
    endtask

    task automatic restart;
        seq_restart = 1'b1;
        tick();
        seq_restart = 1'b0;
        tick(2);
    endtask

    task automatic t_reset_values;
        logic [7:0] q;
        rd(8'h16, q);
        chk8(q, 8'h00, "rail reset");
        rd(8'h18, q);
        chk8(q, 8'h03, "lockout reset");
        rd(8'h19, q);
        chk8(q, 8'h15, "slot reset");
        rd(8'h17, q);
        chk8(q, 8'h00, "unmapped read");
        chk8({1'b0, rails}, 8'h00, "rails at reset");
        chk8({6'h00, lockout_threshold_field_r}, 8'h03, "threshold reset");
    endtask

    task automatic t_protection;
        logic rf;
        logic [7:0] q;
        wr(8'h16, 8'h03, 1'b0, rf);
        chk8({7'h00, rf}, 8'h01, "locked write");
        rd(8'h16, q);
        chk8(q, 8'h00, "locked write kept");
        wr(8'h16, 8'hff, 1'b1, rf);
        chk8({7'h00, rf}, 8'h00, "unlocked write");
        rd(8'h16, q);
        chk8(q, 8'h7f, "bit 7 reads zero");
        wr(8'h18, 8'h00, 1'b0, rf);
        chk8({7'h00, rf}, 8'h01, "unlock reused");
        wr(8'h17, 8'h55, 1'b1, rf);
        chk8({7'h00, rf}, 8'h00, "unmapped write");
        wr(8'h19, 8'h00, 1'b0, rf);
        chk8({7'h00, rf}, 8'h01, "unlock consumed");
        rd(8'h19, q);
        chk8(q, 8'h15, "slots kept");
        rd(8'h18, q);
        chk8(q, 8'h03, "lockout kept");
    endtask

    // Two writes with the strobe held high: the second finds the unlock spent
    task automatic t_back_to_back;
        logic [7:0] q;
        unlock_pulse = 1'b1;
        tick();
        unlock_pulse = 1'b0;
        reg_addr = 8'h16;
        reg_wdata = 8'h01;
        reg_wr = 1'b1;
        tick();
        chk8({7'h00, wr_refused_r}, 8'h00, "first write taken");
        reg_wdata = 8'h02;
        tick();
        chk8({7'h00, wr_refused_r}, 8'h01, "second write refused");
        reg_wr = 1'b0;
        tick();
        rd(8'h16, q);
        chk8(q, 8'h01, "second write dropped");
    endtask

    // Each enable bit alone, with the power pin low and then high
    task automatic t_rail_gating;
        logic rf;
        logic [7:0] d;
        for (int i = 0; i < 7; i++) begin
            d = 8'h01 << i;
            wr(8'h16, d, 1'b1, rf);
            pin(1'b0);
            chk8({1'b0, rails}, d & 8'h03, "rails pin low");
            pin(1'b1);
            chk8({1'b0, rails}, d, "rails pin high");
        end
        wr(8'h16, 8'h00, 1'b1, rf);
        tick(2);
        chk8({1'b0, rails}, 8'h00, "rails cleared");
    endtask

    task automatic t_lockout;
        logic rf;
        logic [7:0] d;
        logic [7:0] q;
        for (int c = 0; c < 4; c++) begin
            d = 8'hf8 | (c[0] ? 8'h04 : 8'h00) | 8'(c);
            wr(8'h18, d, 1'b1, rf);
            rd(8'h18, q);
            chk8(q, d & 8'h07, "lockout readback");
            chk8({6'h00, lockout_threshold_field_r}, 8'(c), "threshold code");
        end
    endtask

    task automatic t_slots;
        logic rf;
        logic [7:0] q;
        wr(8'h19, 8'hff, 1'b1, rf);
        rd(8'h19, q);
        chk8(q, 8'h77, "slot readback");
        for (int n = 1; n < 8; n++) begin
            wr(8'h19, 8'(n), 1'b1, rf);
            restart();
            strobe(3'(n - 1));
            chk8({1'b0, rails}, 8'h00, "early strobe");
            strobe(3'(n));
            chk8({1'b0, rails}, 8'h08, "buck two strobe");
        end
        wr(8'h19, 8'h30, 1'b1, rf);
        restart();
        chk8({1'b0, rails}, 8'h00, "restart clears");
        strobe(3'h3);
        chk8({1'b0, rails}, 8'h10, "buck one strobe");
        pin(1'b0);
        chk8({1'b0, rails}, 8'h00, "strobe needs pin");
    endtask

    // A second reset in mid-run brings back every reset value and disarms the unlock
    task automatic t_mid_reset;
        logic rf;
        logic [7:0] q;
        wr(8'h16, 8'h13, 1'b1, rf);
        unlock_pulse = 1'b1;
        tick();
        unlock_pulse = 1'b0;
        rst_b = 1'b0;
        tick(3);
        rst_b = 1'b1;
        tick();
        chk8({1'b0, rails}, 8'h00, "rails after reset");
        chk8({6'h00, lockout_threshold_field_r}, 8'h03, "threshold after reset");
        rd(8'h16, q);
        chk8(q, 8'h00, "rail after reset");
        rd(8'h18, q);
        chk8(q, 8'h03, "lockout after reset");
        rd(8'h19, q);
        chk8(q, 8'h15, "slots after reset");
        wr(8'h16, 8'h01, 1'b0, rf);
        chk8({7'h00, rf}, 8'h01, "unlock cleared by reset");
    endtask

    initial begin
        tick(3);
        rst_b = 1'b1;
        tick();
        t_reset_values();
        t_protection();
        t_back_to_back();
        t_rail_gating();
        t_lockout();
        t_slots();
        t_mid_reset();
        results();
    end

    // The whole sequence takes a few hundred cycles
    initial begin
        #100000;
        mismatches++;
        results();
    end
endmodule
